// *** rtl/isp_input_sync_params.sv ***
// isp_input_sync_params: input sync parameter entries, sample scheduling,
// cycle time measurement and sync diagnostics, reached over APB.
// assumes event inputs are one-cycle pulses from logic on clk_sys.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module isp_input_sync_params #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned SHIFT_CYC = isp_pkg::SHIFT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire isp_pkg::isp_evt_t evtIn,
    input wire logic opState,
    output logic sampleStrobe,
    output logic irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] satInc16(input logic [15:0] v);
        satInc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction : satInc16

    function automatic logic [31:0] satAddNs(input logic [31:0] v);
        satAddNs = (v > 32'hFFFFFFFF - isp_pkg::CLK_NS) ? 32'hFFFFFFFF : v + isp_pkg::CLK_NS;
    endfunction : satAddNs

    function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
        max32 = (a > b) ? a : b;
    endfunction : max32

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] mode_q;
    logic [31:0] period_q;
    logic [15:0] cmd_q;
    logic [31:0] shift_q;
    logic [31:0] copyLat_q;
    logic [31:0] maxDelay_q;
    logic [15:0] missed_q;
    logic [15:0] overrun_q;
    logic [15:0] shortCnt_q;
    logic fault_q;
    logic [isp_pkg::IRQ_W-1:0] irqStat_q;
    logic [isp_pkg::IRQ_W-1:0] irqEn_q;
    isp_pkg::isp_meas_t meas_q;
    logic [31:0] localNs_q;
    logic [31:0] sinceSync0_q;
    logic [31:0] sinceSync1_q;
    logic [31:0] sinceSample_q;
    logic [15:0] shiftCnt_q;
    logic shiftPend_q;
    logic copyPend_q;
    logic mgrSeen_q;
    logic lateSeen_q;
    logic firstSeen_q;
    logic [31:0] rdData;
    logic rdOk;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic [7:0] regIdx = paddr[9:2];
    wire logic upperZero = (paddr >> 10) == '0;
    wire logic access = psel & penable & ~pready;
    wire logic wrAcc = access & pwrite;
    wire logic rdAcc = access & ~pwrite;
    wire logic wrMode = wrAcc & upperZero & (regIdx == isp_pkg::IDX_MODE_SELECT);
    wire logic wrPeriod = wrAcc & upperZero & (regIdx == isp_pkg::IDX_CYCLE_PERIOD);
    wire logic wrCmd = wrAcc & upperZero & (regIdx == isp_pkg::IDX_MEASURE_CMD);
    wire logic wrIrqClr = wrAcc & upperZero & (regIdx == isp_pkg::IDX_IRQ_CLEAR);
    wire logic wrIrqEn = wrAcc & upperZero & (regIdx == isp_pkg::IDX_IRQ_ENABLE);
    wire logic wrOk = wrMode | wrPeriod | wrCmd | wrIrqClr | wrIrqEn;
    wire logic [15:0] wrHalf = pwdata[15:0];
    // unknown mode codes would leave sampling undefined, so they are refused
    wire logic modeLegal = (wrHalf == isp_pkg::MODE_FREE_RUN)
        | (wrHalf == isp_pkg::MODE_SYNC_MGR3) | (wrHalf == isp_pkg::MODE_CLK_SYNC0)
        | (wrHalf == isp_pkg::MODE_CLK_SYNC1) | (wrHalf == isp_pkg::MODE_SYNC_MGR2);
    wire logic wrErr = wrAcc & (~wrOk | (wrMode & ~modeLegal));
    wire logic rdErr = rdAcc & ~rdOk;

    // ----------------------------------------------------------------
    // mode decode and sample trigger
    // ----------------------------------------------------------------
    wire logic dclkMode = (mode_q == isp_pkg::MODE_CLK_SYNC0)
        | (mode_q == isp_pkg::MODE_CLK_SYNC1);
    wire logic mgrMode = (mode_q == isp_pkg::MODE_SYNC_MGR3)
        | (mode_q == isp_pkg::MODE_SYNC_MGR2);
    wire logic freeMode = (mode_q == isp_pkg::MODE_FREE_RUN);
    wire logic localTick = freeMode & (satAddNs(localNs_q) >= period_q);
    wire logic shiftDone = dclkMode & shiftPend_q & (shiftCnt_q <= 16'h0001);
    wire logic trigger = localTick | (mgrMode & evtIn.mgrEvent)
        | ((mode_q == isp_pkg::MODE_CLK_SYNC0) & shiftDone)
        | ((mode_q == isp_pkg::MODE_CLK_SYNC1) & evtIn.sync1);
    wire logic measuring = (meas_q == isp_pkg::MEAS_RUN);
    wire logic measStart = wrCmd & (wrHalf == isp_pkg::CMD_START);
    // overrun: previous copy not finished or cycle shorter than the floor
    wire logic tooEarly = firstSeen_q & (sinceSample_q < isp_pkg::RST_MIN_CYCLE);
    wire logic overrunEv = opState & trigger & (copyPend_q | tooEarly);
    wire logic missedEv = opState & dclkMode & evtIn.sync0 & firstSeen_q & ~mgrSeen_q;
    wire logic shortEv = dclkMode & evtIn.sync1 & shiftPend_q & ~shiftDone;
    wire logic faultNow = dclkMode & (lateSeen_q | evtIn.outputLate);
    wire logic [isp_pkg::IRQ_W-1:0] irqSet = {evtIn.sync0 & faultNow, shortEv, overrunEv, missedEv};
    wire logic [isp_pkg::IRQ_W-1:0] irqClr = wrIrqClr ? pwdata[isp_pkg::IRQ_W-1:0] : '0;
    wire logic [isp_pkg::IRQ_W-1:0] irqStat_d = (irqStat_q & ~irqClr) | irqSet;
    // an enable written this cycle gates irq at once
    wire logic [isp_pkg::IRQ_W-1:0] irqEnNow = wrIrqEn ? pwdata[isp_pkg::IRQ_W-1:0] : irqEn_q;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rdData = 32'h00000000;
        rdOk = upperZero;
        unique case (regIdx)
            isp_pkg::IDX_ENTRY_COUNT: rdData = {24'h000000, isp_pkg::RST_ENTRY_COUNT};
            isp_pkg::IDX_MODE_SELECT: rdData = {16'h0000, mode_q};
            isp_pkg::IDX_CYCLE_PERIOD: rdData = period_q;
            isp_pkg::IDX_SAMPLE_SHIFT: rdData = shift_q;
            isp_pkg::IDX_SUPPORTED: rdData = {16'h0000, isp_pkg::RST_SUPPORTED};
            isp_pkg::IDX_MIN_CYCLE: rdData = isp_pkg::RST_MIN_CYCLE;
            isp_pkg::IDX_COPY_LATENCY: rdData = copyLat_q;
            isp_pkg::IDX_MIN_DELAY: rdData = isp_pkg::RST_MIN_DELAY;
            isp_pkg::IDX_MEASURE_CMD: rdData = {16'h0000, cmd_q};
            isp_pkg::IDX_MAX_DELAY: rdData = maxDelay_q;
            isp_pkg::IDX_MISSED: rdData = {16'h0000, missed_q};
            isp_pkg::IDX_OVERRUN: rdData = {16'h0000, overrun_q};
            isp_pkg::IDX_SHORT_SHIFT: rdData = {16'h0000, shortCnt_q};
            isp_pkg::IDX_SYNC_FAULT: rdData = {31'h00000000, fault_q};
            isp_pkg::IDX_IRQ_STATUS: rdData = {28'h0000000, irqStat_q};
            isp_pkg::IDX_IRQ_CLEAR: rdData = 32'h00000000;
            isp_pkg::IDX_IRQ_ENABLE: rdData = {28'h0000000, irqEn_q};
            default: rdOk = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // apb answer: one wait state, all outputs registered
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= wrErr | rdErr;
            prdata <= (rdAcc & rdOk) ? rdData : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // writable entries
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= isp_pkg::RST_MODE_SELECT;
            period_q <= isp_pkg::RST_CYCLE_PERIOD;
            cmd_q <= isp_pkg::RST_MEASURE_CMD;
            irqEn_q <= '0;
        end else begin
            if (wrMode & modeLegal) begin
                mode_q <= wrHalf;
            end
            if (wrPeriod) begin
                period_q <= pwdata;
            end
            if (wrCmd) begin
                cmd_q <= wrHalf;
            end
            if (wrIrqEn) begin
                irqEn_q <= pwdata[isp_pkg::IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // measurement control
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meas_q <= isp_pkg::MEAS_IDLE;
        end else if (wrCmd) begin
            unique case (wrHalf)
                isp_pkg::CMD_START: meas_q <= isp_pkg::MEAS_RUN;
                isp_pkg::CMD_STOP: meas_q <= isp_pkg::MEAS_IDLE;
                default: meas_q <= meas_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // measured maxima
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= isp_pkg::RST_SAMPLE_SHIFT;
            copyLat_q <= isp_pkg::RST_COPY_LATENCY;
            maxDelay_q <= isp_pkg::RST_MAX_DELAY;
        end else if (measStart) begin
            shift_q <= 32'h00000000;
            copyLat_q <= 32'h00000000;
            maxDelay_q <= 32'h00000000;
        end else if (measuring & dclkMode) begin
            if (trigger) begin
                shift_q <= max32(shift_q, sinceSync0_q);
                maxDelay_q <= max32(maxDelay_q, sinceSync1_q);
            end
            if (evtIn.copyDone & copyPend_q) begin
                copyLat_q <= max32(copyLat_q, sinceSample_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // interval timers and scheduling
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            localNs_q <= 32'h00000000;
            sinceSync0_q <= 32'h00000000;
            sinceSync1_q <= 32'h00000000;
            sinceSample_q <= 32'h00000000;
            shiftCnt_q <= 16'h0000;
            shiftPend_q <= 1'b0;
        end else begin
            localNs_q <= (localTick | ~freeMode) ? 32'h00000000 : satAddNs(localNs_q);
            sinceSync0_q <= evtIn.sync0 ? isp_pkg::CLK_NS : satAddNs(sinceSync0_q);
            sinceSync1_q <= evtIn.sync1 ? isp_pkg::CLK_NS : satAddNs(sinceSync1_q);
            sinceSample_q <= trigger ? isp_pkg::CLK_NS : satAddNs(sinceSample_q);
            if (evtIn.sync0 & dclkMode) begin
                shiftPend_q <= 1'b1;
                shiftCnt_q <= 16'(SHIFT_CYC);
            end else if (shiftDone | ~dclkMode) begin
                shiftPend_q <= 1'b0;
            end else if (shiftPend_q) begin
                shiftCnt_q <= shiftCnt_q - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // cycle bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            copyPend_q <= 1'b0;
            mgrSeen_q <= 1'b0;
            lateSeen_q <= 1'b0;
            firstSeen_q <= 1'b0;
            sampleStrobe <= 1'b0;
        end else begin
            sampleStrobe <= trigger;
            // a new sample reopens the copy window even if the old one hung
            copyPend_q <= trigger | (copyPend_q & ~evtIn.copyDone);
            firstSeen_q <= firstSeen_q | trigger | evtIn.sync0;
            mgrSeen_q <= evtIn.sync0 ? evtIn.mgrEvent : (mgrSeen_q | evtIn.mgrEvent);
            lateSeen_q <= evtIn.sync0 ? 1'b0 : (lateSeen_q | evtIn.outputLate);
        end
    end

    // ----------------------------------------------------------------
    // diagnostics counters and fault flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            missed_q <= isp_pkg::RST_COUNTER;
            overrun_q <= isp_pkg::RST_COUNTER;
            shortCnt_q <= isp_pkg::RST_COUNTER;
            fault_q <= 1'b0;
        end else begin
            if (missedEv) begin
                missed_q <= satInc16(missed_q);
            end
            if (overrunEv) begin
                overrun_q <= satInc16(overrun_q);
            end
            if (shortEv) begin
                shortCnt_q <= satInc16(shortCnt_q);
            end
            if (~dclkMode) begin
                fault_q <= 1'b0;
            end else if (evtIn.sync0) begin
                fault_q <= faultNow;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts: set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_q <= '0;
            irq <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            irq <= |(irqStat_d & irqEnNow);
        end
    end

endmodule : isp_input_sync_params

`default_nettype wire

// *** rtl/isp_pkg.sv ***
// isp_pkg: constants, indices and carrier types of the input sync parameter block.
// assumes a single 125 MHz system clock and 32-bit APB register access.
package isp_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam logic [31:0] CLK_NS = 32'(1_000_000_000 / CLK_FREQ_HZ);
    localparam int unsigned SHIFT_NS = 900;
    // least time, so round up to whole cycles
    localparam int unsigned SHIFT_CYC = (SHIFT_NS + CLK_NS - 1) / CLK_NS;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] IDX_MODE_SELECT = 8'h01;
    localparam logic [7:0] IDX_CYCLE_PERIOD = 8'h02;
    localparam logic [7:0] IDX_SAMPLE_SHIFT = 8'h03;
    localparam logic [7:0] IDX_SUPPORTED = 8'h04;
    localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
    localparam logic [7:0] IDX_COPY_LATENCY = 8'h06;
    localparam logic [7:0] IDX_MIN_DELAY = 8'h07;
    localparam logic [7:0] IDX_MEASURE_CMD = 8'h08;
    localparam logic [7:0] IDX_MAX_DELAY = 8'h09;
    localparam logic [7:0] IDX_MISSED = 8'h0B;
    localparam logic [7:0] IDX_OVERRUN = 8'h0C;
    localparam logic [7:0] IDX_SHORT_SHIFT = 8'h0D;
    localparam logic [7:0] IDX_SYNC_FAULT = 8'h20;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h22;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h23;

    // ----------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ENTRY_COUNT = 8'h20;
    localparam logic [15:0] RST_MODE_SELECT = 16'h0000;
    localparam logic [31:0] RST_CYCLE_PERIOD = 32'h000F4240;
    localparam logic [31:0] RST_SAMPLE_SHIFT = 32'h00000384;
    localparam logic [15:0] RST_SUPPORTED = 16'h8001;
    localparam logic [31:0] RST_MIN_CYCLE = 32'h00002710;
    localparam logic [31:0] RST_COPY_LATENCY = 32'h00000000;
    localparam logic [31:0] RST_MIN_DELAY = 32'h00000384;
    localparam logic [15:0] RST_MEASURE_CMD = 16'h0000;
    localparam logic [31:0] RST_MAX_DELAY = 32'h00000384;
    localparam logic [15:0] RST_COUNTER = 16'h0000;

    // ----------------------------------------------------------------
    // mode and command codes
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] MODE_SYNC_MGR3 = 16'h0001;
    localparam logic [15:0] MODE_CLK_SYNC0 = 16'h0002;
    localparam logic [15:0] MODE_CLK_SYNC1 = 16'h0003;
    localparam logic [15:0] MODE_SYNC_MGR2 = 16'h0022;
    localparam logic [15:0] CMD_STOP = 16'h0000;
    localparam logic [15:0] CMD_START = 16'h0001;

    // ----------------------------------------------------------------
    // interrupt bit positions
    // ----------------------------------------------------------------
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_MISSED = 0;
    localparam int unsigned IRQ_OVERRUN = 1;
    localparam int unsigned IRQ_SHORT = 2;
    localparam int unsigned IRQ_FAULT = 3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sync0;
        logic sync1;
        logic mgrEvent;
        logic copyDone;
        logic outputLate;
    } isp_evt_t;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b01,
        MEAS_RUN = 2'b10
    } isp_meas_t;

endpackage : isp_pkg

// *** verification/isp_evt_source.sv ***
// isp_evt_source: partner model driving the timing event pulses of the block.
// assumes the bench calls pulse only after a clock edge has passed.
`timescale 1ns/100ps
`default_nettype none
module isp_evt_source (
    input wire logic clk_sys,
    output var isp_pkg::isp_evt_t evt
);
    initial evt = '0;
    // one cycle pulses; an idle edge after each keeps two calls from colliding
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_sys);
        evt <= isp_pkg::isp_evt_t'(m);
        @(posedge clk_sys);
        evt <= '0;
        @(posedge clk_sys);
    endtask : pulse
endmodule : isp_evt_source
`default_nettype wire

// *** verification/isp_input_sync_params_monitor.sv ***
// isp_input_sync_params_monitor: port assertions of the sync parameter block.
// assumes an APB master that holds each request until pready.
`timescale 1ns/100ps
`default_nettype none
module isp_input_sync_params_monitor #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire isp_pkg::isp_evt_t evtIn,
    input wire logic opState,
    input wire logic sampleStrobe,
    input wire logic irq
);
    logic rdDone;
    logic wrDone;
    logic [7:0] cIdx;
    assign cIdx = paddr[9:2];
    assign rdDone = pready && !pwrite && (paddr[ADDR_W-1:10] == '0);
    assign wrDone = pready && pwrite && (paddr[ADDR_W-1:10] == '0);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_wait_state: assert property (psel && penable && !pready |=> pready) else $error("no ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_entry_count: assert property (rdDone && cIdx == 8'h00 |-> prdata == 32'h00000020)
        else $error("entry count wrong");
    a_modes_const: assert property (rdDone && cIdx == 8'h04 |-> prdata == 32'h00008001)
        else $error("supported modes wrong");
    a_min_cycle: assert property (rdDone && cIdx == 8'h05 |-> prdata == 32'h00002710)
        else $error("minimum cycle wrong");
    a_mode_codes: assert property (wrDone && cIdx == 8'h01 && pwdata[31:16] == 16'h0000
        |-> pslverr == !(pwdata[15:0] inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022}))
        else $error("mode code check wrong");
    a_ro_refused: assert property (wrDone && cIdx inside {8'h00, 8'h04, 8'h05, 8'h20}
        |-> pslverr) else $error("read only write taken");
    c_error: cover property (pready && pslverr);
    c_strobe: cover property (sampleStrobe);
    c_irq: cover property (irq);
endmodule : isp_input_sync_params_monitor
bind isp_input_sync_params isp_input_sync_params_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evtIn(evtIn), .opState(opState), .sampleStrobe(sampleStrobe), .irq(irq));
`default_nettype wire

// *** verification/test_input_sync_parameter_block.sv ***
// test_input_sync_parameter_block: self-checking bench against a register model.
// assumes the event source partner and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
module test_input_sync_parameter_block;
    localparam int unsigned SHIFT = 8;
    localparam logic [4:0] S0 = 5'h10, S1 = 5'h08, MG = 5'h04, CP = 5'h02, LATE = 5'h01;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic opState = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sampleStrobe;
    logic irq;
    isp_pkg::isp_evt_t evtIn;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00009381;
    logic [31:0] m [0:35];
    isp_input_sync_params #(.ADDR_W(12), .SHIFT_CYC(SHIFT)) DUT (.clk_sys(clk_sys),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
        .opState(opState), .sampleStrobe(sampleStrobe), .irq(irq));
    isp_evt_source PARTNER (.clk_sys(clk_sys), .evt(evtIn));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            finish_test();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // writable bits only; the clear register stores nothing
    function automatic logic [31:0] wmask(input logic [7:0] idx);
        case (idx)
            8'h01, 8'h08: return 32'h0000FFFF;
            8'h02: return 32'hFFFFFFFF;
            8'h23: return 32'h0000000F;
            default: return 32'h00000000;
        endcase
    endfunction : wmask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic ee);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pslverr}, {31'h0, ee});
        if (!w) chk(prdata, ee ? 32'h0 : m[idx]);
        if (w && !ee) m[idx] = d & wmask(idx);
    endtask : acc
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        logic [7:0] ro [12];
        logic [31:0] codes [5];
        int n;
        ro = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h20, 8'h21};
        codes = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};
        for (int i = 0; i < 36; i++) m[i] = 32'h0;
        m[0] = 32'h20;
        m[2] = 32'h000F4240;
        m[3] = 32'h384;
        m[4] = 32'h8001;
        m[5] = 32'h2710;
        m[7] = 32'h384;
        m[9] = 32'h384;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        // unmapped holes answer with an error and zero data
        for (int i = 0; i < 36; i++) begin
            acc(0, 8'(i), 0, i == 10 || (i > 13 && i < 32));
        end
        foreach (ro[i]) begin
            acc(1, ro[i], xs(), 1);
            acc(0, ro[i], 0, 0);
        end
        foreach (codes[i]) begin
            acc(1, 8'h01, codes[i], 0);
            acc(0, 8'h01, 0, 0);
        end
        acc(1, 8'h01, 32'h00000005, 1);
        acc(1, 8'h02, xs(), 0);
        acc(0, 8'h02, 0, 0);
        $display("test registers done");
        acc(1, 8'h01, 32'h2, 0);
        acc(1, 8'h08, 32'h1, 0);
        m[3] = 32'h0;
        m[6] = 32'h0;
        m[9] = 32'h0;
        for (int i = 3; i < 10; i += 3) acc(0, 8'(i), 0, 0);
        PARTNER.pulse(S0);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sampleStrobe !== 1'b1 && n < 50);
        chk(32'(n), 32'(SHIFT));
        // copy done three edges after the sampling edge, 8 ns each
        PARTNER.pulse(CP);
        m[6] = 32'(3 * 8);
        acc(0, 8'h06, 0, 0);
        m[3] = 32'(8 * SHIFT);
        acc(0, 8'h03, 0, 0);
        acc(1, 8'h08, 32'h0, 0);
        $display("test measurement done");
        PARTNER.pulse(S0 | LATE);
        m[32] = 32'h1;
        m[33] = 32'h8;
        acc(0, 8'h20, 0, 0);
        acc(0, 8'h21, 0, 0);
        chk({31'h0, irq}, 32'h0);
        acc(1, 8'h23, 32'h8, 0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        acc(1, 8'h22, 32'h8, 0);
        m[33] = 32'h0;
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        PARTNER.pulse(S0);
        m[32] = 32'h0;
        acc(0, 8'h20, 0, 0);
        $display("test fault done");
        PARTNER.pulse(MG);
        PARTNER.pulse(S0);
        opState <= 1'b1;
        PARTNER.pulse(S0);
        opState <= 1'b0;
        PARTNER.pulse(S0);
        PARTNER.pulse(S1);
        acc(1, 8'h01, 32'h1, 0);
        opState <= 1'b1;
        PARTNER.pulse(CP);
        // more than the minimum cycle apart, then far too close
        repeat (1300) @(posedge clk_sys);
        PARTNER.pulse(MG);
        PARTNER.pulse(MG);
        opState <= 1'b0;
        m[11] = 32'h1;
        m[12] = 32'h1;
        m[13] = 32'h1;
        m[33] = 32'h7;
        for (int i = 11; i < 14; i++) acc(0, 8'(i), 0, 0);
        acc(0, 8'h21, 0, 0);
        $display("test counters done");
        // free run: 64 ns period gives one sample every 8 cycles
        acc(1, 8'h02, 32'h00000040, 0);
        acc(1, 8'h01, 32'h0, 0);
        while (sampleStrobe !== 1'b1) begin
            @(posedge clk_sys);
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sampleStrobe !== 1'b1 && n < 50);
        chk(32'(n), 32'h40 / 8);
        acc(1, 8'h01, 32'h3, 0);
        PARTNER.pulse(S1);
        chk({31'h0, sampleStrobe}, 32'h1);
        $display("test free run done");
        finish_test();
    end
endmodule : test_input_sync_parameter_block
`default_nettype wire
